// file: design/rtp_defs.svh
// Register indices, field positions and reset values of the pattern output port
`ifndef RTP_DEFS_SVH
`define RTP_DEFS_SVH

`define RTP_ADDR_W 16
`define RTP_DATA_W 32
`define RTP_PINS 6

// Register indices (word addresses on the bus)
`define RTP_IDX_MOD_CTRL 16'hFF38
`define RTP_IDX_PWM_SRC 16'hFF39
`define RTP_IDX_PIN_MASK 16'hFFBC
`define RTP_IDX_BUF_LOW 16'hFFB0
`define RTP_IDX_BUF_HIGH 16'hFFB1
`define RTP_IDX_PORT_CTRL 16'hFFB2
`define RTP_IDX_LATCH_STAT 16'hFFB3

// Field positions
`define RTP_BIT_OUT_EN 7
`define RTP_BIT_WIDTH 5
`define RTP_BIT_DIRECT 7
`define RTP_BIT_MOD_HIGH 6
`define RTP_BIT_MOD_LOW 5
`define RTP_BIT_INVERT 4
`define RTP_BIT_PWM_SEL 0
`define RTP_LOW_W 4
`define RTP_HIGH_W 2

// Reset values
`define RTP_RST_BYTE 8'h00
`define RTP_RST_LOW 4'h0
`define RTP_RST_HIGH 2'h0
`define RTP_RST_PINS 6'h00
`define RTP_RST_WORD 32'h00000000

`endif

// file: design/rtp_pkg.sv
// Types shared by the pattern output port modules
package rtp_pkg;
    // Bus handshake state
    typedef enum logic [0:0] {
        RTP_BUS_IDLE = 1'b0,
        RTP_BUS_ACK = 1'b1
    } rtp_bus_e;
endpackage : rtp_pkg

// file: design/rtp_pin_mux.sv
// Per-pin output selection of the pattern output port
`timescale 1ns/1ns
`default_nettype none
`include "rtp_defs.svh"
module rtp_pin_mux
    import rtp_pkg::*;
(
    input wire logic counter_en,
    input wire logic direct_sel,
    input wire logic invert,
    input wire logic mod_high,
    input wire logic mod_low,
    input wire logic per_chan,
    input wire logic out_en,
    input wire logic [`RTP_PINS-1:0] mask,
    input wire logic [`RTP_PINS-1:0] latch,
    input wire logic [`RTP_PINS-1:0] tout,
    output logic [`RTP_PINS-1:0] level,
    output logic [`RTP_PINS-1:0] drive
);
    genvar n;
    generate
        for (n = 0; n < `RTP_PINS; n = n + 1) begin : g_pin
            logic sel_t;
            logic mod_t;
            logic pat_t;
            // Channel 0 for all pins, or each pin its own channel
            assign sel_t = per_chan ? tout[n] : tout[0];
            // Even pins follow the high group, odd pins the low group
            assign mod_t = ((n % 2) == 0) ? mod_high : mod_low;
            assign pat_t = out_en & mask[n] & latch[n];
            always_comb begin
                if (!direct_sel) begin
                    level[n] = sel_t;
                end else if (mod_t && mask[n] && !pat_t) begin
                    // Timer passes through while the pattern is 0 or idle
                    level[n] = sel_t;
                end else begin
                    level[n] = pat_t ^ invert;
                end
                drive[n] = counter_en;
            end
        end
    endgenerate
endmodule : rtp_pin_mux
`default_nettype wire

// file: design/rtp_bus_if.sv
// Avalon-MM slave handshake with one wait state and registered read data
`timescale 1ns/1ns
`default_nettype none
`include "rtp_defs.svh"
module rtp_bus_if
    import rtp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [`RTP_DATA_W-1:0] rd_word,
    output logic take,
    output logic avs_waitrequest,
    output logic [`RTP_DATA_W-1:0] avs_readdata
);
    rtp_bus_e state_ff;
    rtp_bus_e nxt_state;
    logic [`RTP_DATA_W-1:0] rdata_ff;
    logic [`RTP_DATA_W-1:0] nxt_rdata;

    // Access acts once, in the idle cycle; the ack cycle only releases the master
    assign take = (avs_read | avs_write) & (state_ff == RTP_BUS_IDLE);
    assign avs_waitrequest = (state_ff != RTP_BUS_ACK);
    assign avs_readdata = rdata_ff;

    always_comb begin
        nxt_rdata = rdata_ff;
        case (state_ff)
            RTP_BUS_IDLE: begin
                nxt_state = take ? RTP_BUS_ACK : RTP_BUS_IDLE;
                if (take && avs_read) begin
                    nxt_rdata = rd_word;
                end
            end
            RTP_BUS_ACK: nxt_state = RTP_BUS_IDLE;
            default: nxt_state = RTP_BUS_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            state_ff <= RTP_BUS_IDLE;
            rdata_ff <= `RTP_RST_WORD;
        end else begin
            state_ff <= nxt_state;
            rdata_ff <= nxt_rdata;
        end
    end
endmodule : rtp_bus_if
`default_nettype wire

// file: design/rtp_port.sv
// Real-time pattern output port: registers, buffer, trigger latch and pin drive
// Function
// - PWM source bit 0 uses timer channel 0; 1 uses each pin's channel.
// - PWM source register resets to zero and accepts bit or byte writes.
// - With output enabled, buffer is copied to latch on every timer trigger.
// - Only pins whose mask bit is 1 show the transferred pattern.
// - Width bit 5 of port control selects one 6-bit or 4-bit channel.
// - Direct select 0 with counter running: pins carry the chosen timer signal.
// - Counter enable 0 puts every pin in high impedance.
// - Unmodulated direct output without invert is high only for enable, mask and pattern all 1.
// - Invert bit complements every constant level the pin would give.
// - Modulated masked pin: timer when pattern 0 or disabled, active level on 1.
// - Disabled output, mask 1, modulation on: pin shows the selected timer signal.
// - In 6-bit mode either buffer address writes and reads all six bits.
// - Invert and modulation bits act only when direct select is 1.
// - High group modulation drives pins 0,2,4; low group drives 1,3,5.
`timescale 1ns/1ns
`default_nettype none
`include "rtp_defs.svh"
module rtp_port
    import rtp_pkg::*;
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [`RTP_ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [`RTP_DATA_W-1:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [`RTP_DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic timer_trigger_irq,
    input wire logic inv_counter_enable,
    input wire logic [`RTP_PINS-1:0] inverter_timer_out_pin,
    output logic [`RTP_PINS-1:0] pattern_pin_out,
    output logic [`RTP_PINS-1:0] pattern_pin_oe
);
    // Software-visible control state
    logic out_en_ff, nxt_out_en;
    logic width6_ff, nxt_width6;
    logic [`RTP_LOW_W-1:0] buf_low_ff, nxt_buf_low;
    logic [`RTP_HIGH_W-1:0] buf_high_ff, nxt_buf_high;
    logic [`RTP_PINS-1:0] mask_reg_ff, nxt_mask_reg;
    logic direct_ff, nxt_direct;
    logic mod_high_ff, nxt_mod_high;
    logic mod_low_ff, nxt_mod_low;
    logic invert_ff, nxt_invert;
    logic pwm_sel_ff, nxt_pwm_sel;
    // Pattern path state
    logic [`RTP_PINS-1:0] latch_ff, nxt_latch;
    logic [`RTP_PINS-1:0] mask_eff_ff, nxt_mask_eff;
    logic [`RTP_PINS-1:0] pin_out_ff, pin_oe_ff;
    logic [`RTP_PINS-1:0] mux_level, mux_drive;
    // Bus decode
    logic take;
    logic wr_lo;
    logic [7:0] wbyte;
    logic [`RTP_DATA_W-1:0] rd_word;
    logic [`RTP_PINS-1:0] buf_word;
    logic fire;

    rtp_bus_if u_bus (
        .clk(clk),
        .nrst(nrst),
        .avs_read(avs_read),
        .avs_write(avs_write),
        .rd_word(rd_word),
        .take(take),
        .avs_waitrequest(avs_waitrequest),
        .avs_readdata(avs_readdata)
    );

    // Only the low byte lane carries register data; upper lanes are ignored
    assign wr_lo = take & avs_write & avs_byteenable[0];
    assign wbyte = avs_writedata[7:0];
    assign buf_word = {buf_high_ff, buf_low_ff};
    assign fire = timer_trigger_irq & out_en_ff;

    // Read mux; unmapped indices return zero
    always_comb begin
        rd_word = `RTP_RST_WORD;
        case (avs_address)
            `RTP_IDX_BUF_LOW, `RTP_IDX_BUF_HIGH: begin
                // 4-bit mode hides the high bits from either address
                if (width6_ff) begin
                    rd_word[`RTP_PINS-1:0] = buf_word;
                end else begin
                    rd_word[`RTP_LOW_W-1:0] = buf_low_ff;
                end
            end
            `RTP_IDX_PORT_CTRL: begin
                rd_word[`RTP_BIT_OUT_EN] = out_en_ff;
                rd_word[`RTP_BIT_WIDTH] = width6_ff;
            end
            `RTP_IDX_PIN_MASK: rd_word[`RTP_PINS-1:0] = mask_reg_ff;
            `RTP_IDX_MOD_CTRL: begin
                rd_word[`RTP_BIT_DIRECT] = direct_ff;
                rd_word[`RTP_BIT_MOD_HIGH] = mod_high_ff;
                rd_word[`RTP_BIT_MOD_LOW] = mod_low_ff;
                rd_word[`RTP_BIT_INVERT] = invert_ff;
            end
            `RTP_IDX_PWM_SRC: rd_word[`RTP_BIT_PWM_SEL] = pwm_sel_ff;
            `RTP_IDX_LATCH_STAT: rd_word[`RTP_PINS-1:0] = latch_ff;
            default: rd_word = `RTP_RST_WORD;
        endcase
    end

    // Register writes; bit writes arrive as whole-byte read-modify-write
    always_comb begin
        nxt_out_en = out_en_ff;
        nxt_width6 = width6_ff;
        nxt_buf_low = buf_low_ff;
        nxt_buf_high = buf_high_ff;
        nxt_mask_reg = mask_reg_ff;
        nxt_direct = direct_ff;
        nxt_mod_high = mod_high_ff;
        nxt_mod_low = mod_low_ff;
        nxt_invert = invert_ff;
        nxt_pwm_sel = pwm_sel_ff;
        if (wr_lo) begin
            case (avs_address)
                `RTP_IDX_BUF_LOW: begin
                    nxt_buf_low = wbyte[`RTP_LOW_W-1:0];
                    if (width6_ff) begin
                        nxt_buf_high = wbyte[`RTP_PINS-1:`RTP_LOW_W];
                    end
                end
                `RTP_IDX_BUF_HIGH: begin
                    // High address is dead in 4-bit mode
                    if (width6_ff) begin
                        nxt_buf_low = wbyte[`RTP_LOW_W-1:0];
                        nxt_buf_high = wbyte[`RTP_PINS-1:`RTP_LOW_W];
                    end
                end
                `RTP_IDX_PORT_CTRL: begin
                    nxt_out_en = wbyte[`RTP_BIT_OUT_EN];
                    nxt_width6 = wbyte[`RTP_BIT_WIDTH];
                end
                `RTP_IDX_PIN_MASK: nxt_mask_reg = wbyte[`RTP_PINS-1:0];
                `RTP_IDX_MOD_CTRL: begin
                    nxt_direct = wbyte[`RTP_BIT_DIRECT];
                    nxt_mod_high = wbyte[`RTP_BIT_MOD_HIGH];
                    nxt_mod_low = wbyte[`RTP_BIT_MOD_LOW];
                    nxt_invert = wbyte[`RTP_BIT_INVERT];
                end
                `RTP_IDX_PWM_SRC: nxt_pwm_sel = wbyte[`RTP_BIT_PWM_SEL];
                default: nxt_pwm_sel = pwm_sel_ff;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            out_en_ff <= 1'b0;
            width6_ff <= 1'b0;
            buf_low_ff <= `RTP_RST_LOW;
            buf_high_ff <= `RTP_RST_HIGH;
            mask_reg_ff <= `RTP_RST_PINS;
            direct_ff <= 1'b0;
            mod_high_ff <= 1'b0;
            mod_low_ff <= 1'b0;
            invert_ff <= 1'b0;
            pwm_sel_ff <= 1'b0;
        end else begin
            out_en_ff <= nxt_out_en;
            width6_ff <= nxt_width6;
            buf_low_ff <= nxt_buf_low;
            buf_high_ff <= nxt_buf_high;
            mask_reg_ff <= nxt_mask_reg;
            direct_ff <= nxt_direct;
            mod_high_ff <= nxt_mod_high;
            mod_low_ff <= nxt_mod_low;
            invert_ff <= nxt_invert;
            pwm_sel_ff <= nxt_pwm_sel;
        end
    end

    // Trigger transfer; the mask too is resynchronised to the trigger while enabled
    always_comb begin
        nxt_latch = latch_ff;
        nxt_mask_eff = out_en_ff ? mask_eff_ff : mask_reg_ff;
        if (fire) begin
            nxt_mask_eff = mask_reg_ff;
            if (width6_ff) begin
                nxt_latch = buf_word;
            end else begin
                nxt_latch[`RTP_LOW_W-1:0] = buf_low_ff;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            latch_ff <= `RTP_RST_PINS;
            mask_eff_ff <= `RTP_RST_PINS;
        end else begin
            latch_ff <= nxt_latch;
            mask_eff_ff <= nxt_mask_eff;
        end
    end

    rtp_pin_mux u_mux (
        .counter_en(inv_counter_enable),
        .direct_sel(direct_ff),
        .invert(invert_ff),
        .mod_high(mod_high_ff),
        .mod_low(mod_low_ff),
        .per_chan(pwm_sel_ff),
        .out_en(out_en_ff),
        .mask(mask_eff_ff),
        .latch(latch_ff),
        .tout(inverter_timer_out_pin),
        .level(mux_level),
        .drive(mux_drive)
    );

    // Pins registered together, one clock behind latch and timer inputs
    always_ff @(posedge clk) begin
        if (!nrst) begin
            pin_out_ff <= `RTP_RST_PINS;
            pin_oe_ff <= `RTP_RST_PINS;
        end else begin
            pin_out_ff <= mux_level;
            pin_oe_ff <= mux_drive;
        end
    end

    assign pattern_pin_out = pin_out_ff;
    assign pattern_pin_oe = pin_oe_ff;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);

    sequence s_req_taken;
        (avs_read || avs_write) && avs_waitrequest;
    endsequence
    sequence s_ack_once;
        !avs_waitrequest ##1 avs_waitrequest;
    endsequence

    a_bus_ack_once: assert property (s_req_taken |=> s_ack_once)
        else $error("bus request not acknowledged for exactly one cycle");
    a_latch_six_copy: assert property (fire && width6_ff |=> latch_ff == $past(buf_word))
        else $error("latch did not take buffer on trigger");
    a_latch_hold_idle: assert property (!fire |=> $stable(latch_ff))
        else $error("latch changed without trigger");
    a_four_bit_keep: assert property (fire && !width6_ff |=> latch_ff[5:4] == $past(latch_ff[5:4]))
        else $error("4-bit mode disturbed high latch bits");
    a_pin_hiz_stop: assert property (!inv_counter_enable |=> pattern_pin_oe == 6'h00)
        else $error("pins driven while counter stopped");
    a_timer_direct: assert property (!direct_ff && !pwm_sel_ff |=>
        pattern_pin_out == {6{$past(inverter_timer_out_pin[0])}})
        else $error("direct timer path wrong");
    a_pwm_sel_reset: assert property ($rose(nrst) |-> !pwm_sel_ff)
        else $error("pwm source select not cleared by reset");
    a_masked_pin_low: assert property (direct_ff && !invert_ff && !mask_eff_ff[0] |=> !pattern_pin_out[0])
        else $error("masked pin not low");
    a_invert_level: assert property (direct_ff && invert_ff && !mod_high_ff && !mod_low_ff |=>
        pattern_pin_out == ~$past(out_en_ff ? (mask_eff_ff & latch_ff) : 6'h00))
        else $error("inverted constant level wrong");
    a_mod_pass_timer: assert property (direct_ff && mod_high_ff && mask_eff_ff[0] && !(out_en_ff && latch_ff[0])
        && !pwm_sel_ff |=> pattern_pin_out[0] == $past(inverter_timer_out_pin[0]))
        else $error("modulated pin did not pass timer");
    a_six_bit_write: assert property (wr_lo && width6_ff && avs_address == `RTP_IDX_BUF_HIGH |=>
        buf_word == $past(avs_writedata[5:0]))
        else $error("6-bit buffer write incomplete");
endmodule : rtp_port
`default_nettype wire

// file: sim/rtp_gate_drv.sv
// Gate driver input stage facing the pattern pins
`timescale 1ns/1ns
`default_nettype none
module rtp_gate_drv (
    input wire logic [5:0] pin_out,
    input wire logic [5:0] pin_oe,
    output logic [5:0] gate_lvl
);
    // Released pins fall to the driver's pull-down, never hold the last value
    always_comb begin
        for (int i = 0; i < 6; i++) begin
            gate_lvl[i] = pin_oe[i] ? pin_out[i] : 1'h0;
        end
    end
endmodule : rtp_gate_drv
`default_nettype wire

// file: sim/rtp_port_tb.sv
// Self-checking bench for the pattern output port
`timescale 1ns/1ns
`default_nettype none
`include "rtp_defs.svh"
module rtp_port_tb
    import rtp_pkg::*;
;
    logic clk, nrst, rd, wr, wreq, trig, ce;
    logic [15:0] addr;
    logic [31:0] wdata, rdata, seed, r, q;
    logic [3:0] be;
    logic [5:0] tout, pout, poe, gate;
    int errors, n_tests;
    // Reference state of the port
    logic [7:0] m_mod;
    logic m_pwm, m_en, m_w;
    logic [5:0] m_mask, m_emask, m_buf, m_latch;

    rtp_port i_rtp_port (.clk(clk), .nrst(nrst), .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdata), .avs_byteenable(be), .avs_readdata(rdata), .avs_waitrequest(wreq),
        .timer_trigger_irq(trig), .inv_counter_enable(ce), .inverter_timer_out_pin(tout),
        .pattern_pin_out(pout), .pattern_pin_oe(poe));
    rtp_gate_drv i_rtp_gate_drv (.pin_out(pout), .pin_oe(poe), .gate_lvl(gate));

    // Free-running 50 MHz clock
    initial begin
        clk = 1'h0;
        forever #10 clk = ~clk;
    end

    task automatic test_done;
        $display("errors %0d tests %0d", errors, n_tests);
        if (errors == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : test_done

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic step;
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        r = seed;
    endtask : step

    // One Avalon access; request held until waitrequest is seen low
    task automatic bus(input logic w, input logic [15:0] a, input logic [7:0] d, input logic b0);
        int n;
        @(posedge clk);
        addr <= a;
        wdata <= {24'h000000, d};
        be <= {3'h7, b0};
        rd <= !w;
        wr <= w;
        // Look for the answer mid-cycle, then take it at the next rising edge
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (wreq !== 1'h0 && n < 50);
        // A slave that never answers counts against the run
        if (wreq !== 1'h0) errors++;
        @(posedge clk);
        q = rdata;
        rd <= 1'h0;
        wr <= 1'h0;
    endtask : bus

    task automatic wreg(input logic [15:0] a, input logic [7:0] d);
        bus(1'h1, a, d, 1'h1);
        case (a)
            `RTP_IDX_MOD_CTRL: m_mod = d;
            `RTP_IDX_PWM_SRC: m_pwm = d[0];
            `RTP_IDX_PIN_MASK: m_mask = d[5:0];
            `RTP_IDX_BUF_LOW: if (m_w) m_buf = d[5:0]; else m_buf[3:0] = d[3:0];
            `RTP_IDX_BUF_HIGH: if (m_w) m_buf = d[5:0];
            `RTP_IDX_PORT_CTRL: {m_en, m_w} = {d[7], d[5]};
            default: ;
        endcase
        if (!m_en) m_emask = m_mask;
    endtask : wreg

    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        bus(1'h0, a, 8'h00, 1'h1);
        chk(q, {24'h000000, e});
    endtask : rchk

    // One-cycle trigger pulse; latch follows only while output is enabled
    task automatic trigger;
        @(posedge clk);
        trig <= 1'h1;
        @(posedge clk);
        trig <= 1'h0;
        if (m_en) begin
            m_latch = m_w ? m_buf : {m_latch[5:4], m_buf[3:0]};
            m_emask = m_mask;
        end
    endtask : trigger

    // Pins lag the settings by one edge, so let them settle before comparing
    task automatic pins_chk;
        logic [5:0] eo;
        logic s, p, g;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            s = m_pwm ? tout[i] : tout[0];
            p = m_en & m_emask[i] & m_latch[i];
            g = (i % 2 == 0) ? m_mod[`RTP_BIT_MOD_HIGH] : m_mod[`RTP_BIT_MOD_LOW];
            if (!m_mod[`RTP_BIT_DIRECT] || (g & m_emask[i] & !p))
                eo[i] = s;
            else
                eo[i] = p ^ m_mod[`RTP_BIT_INVERT];
        end
        chk({26'h0, poe}, ce ? 32'h3F : 32'h0);
        chk({26'h0, gate}, {26'h0, ce ? eo : 6'h00});
    endtask : pins_chk

    // Hang guard well beyond the expected run length
    initial begin
        #(20 * 60000);
        errors++;
        test_done;
    end

    initial begin
        {rd, wr, trig, addr, wdata, be} = '0;
        {m_mod, m_pwm, m_en, m_w, m_mask, m_emask, m_buf, m_latch} = '0;
        {errors, n_tests} = '0;
        ce = 1'h1;
        tout = 6'h00;
        seed = 32'h3370;
        nrst = 1'h0;
        repeat (10) @(posedge clk);
        nrst <= 1'h1;
        // Reset values, then a write with its byte lane off
        rchk(`RTP_IDX_PWM_SRC, 8'h00);
        rchk(`RTP_IDX_MOD_CTRL, 8'h00);
        rchk(`RTP_IDX_PIN_MASK, 8'h00);
        bus(1'h1, `RTP_IDX_PWM_SRC, 8'h01, 1'h0);
        rchk(`RTP_IDX_PWM_SRC, 8'h00);
        // Software bring-up order: disable, configure, enable
        wreg(`RTP_IDX_PORT_CTRL, 8'h20);
        wreg(`RTP_IDX_PIN_MASK, 8'h3F);
        wreg(`RTP_IDX_BUF_HIGH, 8'h2A);
        wreg(`RTP_IDX_MOD_CTRL, 8'h80);
        wreg(`RTP_IDX_PORT_CTRL, 8'hA0);
        pins_chk;
        for (int k = 0; k < 150; k++) begin
            step;
            case (r[2:0])
                3'h0: wreg(`RTP_IDX_MOD_CTRL, {r[11:8], 4'h0});
                3'h1: wreg(`RTP_IDX_PWM_SRC, {7'h00, r[8]});
                3'h2: wreg(`RTP_IDX_PIN_MASK, {2'h0, r[13:8]});
                3'h3: wreg(r[8] ? `RTP_IDX_BUF_LOW : `RTP_IDX_BUF_HIGH, {2'h0, r[14:9]});
                3'h4: trigger;
                3'h5: begin
                    @(posedge clk);
                    tout <= r[13:8];
                    ce <= (r[15:14] != 2'h0);
                end
                3'h6: begin
                    wreg(`RTP_IDX_PORT_CTRL, {2'h0, r[8], 5'h00});
                    pins_chk;
                    wreg(`RTP_IDX_BUF_LOW, {2'h0, m_latch});
                    wreg(`RTP_IDX_PORT_CTRL, {2'h2, m_w, 5'h00});
                end
                default: begin
                    rchk(`RTP_IDX_PIN_MASK, {2'h0, m_mask});
                    rchk(`RTP_IDX_LATCH_STAT, {2'h0, m_latch});
                    rchk(`RTP_IDX_MOD_CTRL, m_mod);
                    rchk(`RTP_IDX_PWM_SRC, {7'h00, m_pwm});
                    rchk(`RTP_IDX_PORT_CTRL, {m_en, 1'h0, m_w, 5'h00});
                    if (m_w) rchk(r[8] ? `RTP_IDX_BUF_LOW : `RTP_IDX_BUF_HIGH, {2'h0, m_buf});
                    wreg(16'hFF00, 8'h5A);
                    rchk(16'hFF00, 8'h00);
                end
            endcase
            pins_chk;
        end
        test_done;
    end
endmodule : rtp_port_tb
`default_nettype wire
